// [hw/rsse_pkg.sv]
// package: constants, opcodes and carriers for the rotate/subtract/sleep executor
package rsse_pkg;
  localparam int ADDR_W = 7;                       // file register address width
  localparam int DATA_W = 8;                       // datapath width
  localparam int NREGS  = 128;                     // file register count
  // axi-lite register byte offsets
  localparam logic [7:0] OFF_CMD    = 8'h00;       // write: issue an instruction
  localparam logic [7:0] OFF_WREG   = 8'h04;       // working register
  localparam logic [7:0] OFF_STATUS = 8'h08;       // status flags
  localparam logic [7:0] OFF_FADDR  = 8'h0c;       // file register window address
  localparam logic [7:0] OFF_FDATA  = 8'h10;       // file register window data
  localparam logic [7:0] OFF_CORE   = 8'h14;       // core state, watchdog
  // command word fields
  localparam int CMD_OP_LSB  = 0;                  // opcode bits [1:0]
  localparam int CMD_D_BIT   = 2;                  // destination select
  localparam int CMD_F_LSB   = 8;                  // file address [14:8]
  localparam int CMD_K_LSB   = 16;                 // literal [23:16]
  // status bit positions
  localparam int ST_C  = 0;                        // carry
  localparam int ST_DC = 1;                        // digit carry
  localparam int ST_Z  = 2;                        // zero
  localparam int ST_PD = 3;                        // powerdown
  localparam int ST_TO = 4;                        // timeout
  localparam logic [7:0] STATUS_RST = 8'h18;       // timeout and powerdown set at reset
  localparam int WDT_W   = 8;                      // watchdog counter width
  localparam int PRESC_W = 7;                      // watchdog prescaler width
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0]
  {
    OP_RLC = 2'h0,                                 // rotate left through carry
    OP_RRC = 2'h1,                                 // rotate right through carry
    OP_SUB = 2'h2,                                 // literal minus working reg
    OP_SLP = 2'h3                                  // sleep
  } rsse_op_e;

  // one decoded instruction
  typedef struct packed
  {
    rsse_op_e          op;
    logic              dest_select;
    logic [ADDR_W-1:0] file_reg_addr;
    logic [DATA_W-1:0] literal;
  } rsse_instr_s;

  // alu result bundle
  typedef struct packed
  {
    logic [DATA_W-1:0] value;
    logic              carry_flag;
    logic              digit_carry_flag;
    logic              zero_flag;
    logic              upd_dc_z;
  } rsse_alu_s;
endpackage

// [hw/rsse_alu.sv]
// combinational alu for rotate and subtract-from-literal
`timescale 1ns/1ps
`default_nettype none
module rsse_alu
(
  input  wire rsse_pkg::rsse_op_e        op,
  input  wire logic [rsse_pkg::DATA_W-1:0] operand_f,
  input  wire logic [rsse_pkg::DATA_W-1:0] working_reg,
  input  wire logic [rsse_pkg::DATA_W-1:0] literal,
  input  wire logic                        carry_in,
  output rsse_pkg::rsse_alu_s            res
);
  import rsse_pkg::*;

  logic [DATA_W:0]   diff;                         // nine bit difference, msb is borrow
  logic [4:0]        ndiff;                        // nibble difference

  // a separate nibble subtract serves digit carry; borrow clear means "no borrow" = carry set
  always_comb
  begin
    diff  = {1'b0, literal} - {1'b0, working_reg};
    ndiff = {1'b0, literal[3:0]} - {1'b0, working_reg[3:0]};
    res   = '0;
    case (op)
      OP_RLC:
      begin
        res.value      = {operand_f[DATA_W-2:0], carry_in};
        res.carry_flag = operand_f[DATA_W-1];
      end
      OP_RRC:
      begin
        res.value      = {carry_in, operand_f[DATA_W-1:1]};
        res.carry_flag = operand_f[0];
      end
      OP_SUB:
      begin
        res.value            = diff[DATA_W-1:0];
        res.carry_flag       = ~diff[DATA_W];
        res.digit_carry_flag = ~ndiff[4];
        res.zero_flag        = (diff[DATA_W-1:0] == 8'h00);
        res.upd_dc_z         = 1'b1;
      end
      default:
      begin
        res.carry_flag = carry_in;                 // sleep: no alu effect
      end
    endcase
  end
endmodule
`default_nettype wire

// [hw/rsse_regfile.sv]
// 128 x 8 file register array in flip-flops
`timescale 1ns/1ps
`default_nettype none
module rsse_regfile
#(
  parameter int DEPTH = 128
)
(
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [rsse_pkg::ADDR_W-1:0] rd_addr,
  output logic      [rsse_pkg::DATA_W-1:0] rd_data,
  input  wire logic                        wr_en,
  input  wire logic [rsse_pkg::ADDR_W-1:0] wr_addr,
  input  wire logic [rsse_pkg::DATA_W-1:0] wr_data
);
  import rsse_pkg::*;

  logic [DATA_W-1:0] mem_r   [DEPTH];              // storage
  logic [DATA_W-1:0] mem_nxt [DEPTH];              // next storage

  assign rd_data = mem_r[rd_addr];                 // asynchronous read

  // next state: only the addressed entry changes
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      mem_nxt[i] = mem_r[i];
    end
    if (wr_en)
    begin
      mem_nxt[wr_addr] = wr_data;
    end
  end

  // registers cleared by reset
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      if (!aresetn)
        mem_r[i] <= '0;
      else
        mem_r[i] <= mem_nxt[i];
    end
  end
endmodule
`default_nettype wire

// [hw/rsse_core.sv]
// executor top: axi-lite slave, one-cycle instruction execute, sleep state
//
// Contract
// - rotate left: carry in bit0, bit7 to carry
// - rotate right: carry in bit7, bit0 to carry
// - dest 0 writes working reg, 1 file reg
// - seven bit file address, one bit dest
// - sleep clears watchdog counter and prescaler
// - sleep clears powerdown, sets timeout only
// - sleep halts oscillator, stops executing
// - literal minus working reg into working
// - carry and digit carry mean no borrow
`timescale 1ns/1ps
`default_nettype none
module rsse_core
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        wake,
  output logic             osc_run,
  output logic             sleeping
);
  import rsse_pkg::*;

  // write channel state
  logic        aw_have_r,  aw_have_nxt;            // address latched
  logic [7:0]  aw_addr_r,  aw_addr_nxt;
  logic        w_have_r,   w_have_nxt;             // data latched
  logic [31:0] w_data_r,   w_data_nxt;
  logic [3:0]  w_strb_r,   w_strb_nxt;
  logic        bvalid_r,   bvalid_nxt;
  logic [1:0]  bresp_r,    bresp_nxt;
  // read channel state
  logic        rvalid_r,   rvalid_nxt;
  logic [31:0] rdata_r,    rdata_nxt;
  logic [1:0]  rresp_r,    rresp_nxt;
  // core state
  logic [DATA_W-1:0]  wreg_r,   wreg_nxt;          // working register
  logic [7:0]         status_r, status_nxt;        // status flags
  logic [ADDR_W-1:0]  faddr_r,  faddr_nxt;         // file window pointer
  logic [WDT_W-1:0]   wdt_r,    wdt_nxt;           // watchdog_counter
  logic [PRESC_W-1:0] presc_r,  presc_nxt;         // watchdog prescaler
  logic               sleep_r,  sleep_nxt;         // core asleep

  logic        wr_fire;                            // both halves present
  logic        exec;                               // instruction accepted
  rsse_instr_s instr;                              // decoded command
  rsse_alu_s   alu;                                // alu outputs
  logic [DATA_W-1:0]  rf_rd_data;
  logic [ADDR_W-1:0]  rf_rd_addr;
  logic               rf_wr_en;
  logic [ADDR_W-1:0]  rf_wr_addr;
  logic [DATA_W-1:0]  rf_wr_data;
  logic [31:0]        wreg_mg;                     // working reg merged with the write
  logic [31:0]        status_mg;                   // status merged with the write
  logic [31:0]        faddr_mg;                    // window pointer merged with the write

  // merge byte enables into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // known offset check shared by read and write decode
  function automatic logic mapped(input logic [7:0] a);
    return (a == OFF_CMD) || (a == OFF_WREG) || (a == OFF_STATUS) ||
           (a == OFF_FADDR) || (a == OFF_FDATA) || (a == OFF_CORE);
  endfunction

  // handshakes: one write in flight, accept halves in either order
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready  = !w_have_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign sleeping      = sleep_r;
  assign osc_run       = !sleep_r;

  assign wr_fire = aw_have_r && w_have_r;

  // byte-lane merges for the direct pokes; a call result cannot be part-selected
  assign wreg_mg   = merge({24'h0, wreg_r}, w_data_r, w_strb_r);
  assign status_mg = merge({24'h0, status_r}, w_data_r, w_strb_r);
  assign faddr_mg  = merge({25'h0, faddr_r}, w_data_r, w_strb_r);

  // command decode; address field is seven bits wide by construction
  always_comb
  begin
    instr.op            = rsse_op_e'(w_data_r[CMD_OP_LSB +: 2]);
    instr.dest_select   = w_data_r[CMD_D_BIT];
    instr.file_reg_addr = w_data_r[CMD_F_LSB +: ADDR_W];
    instr.literal       = w_data_r[CMD_K_LSB +: DATA_W];
  end

  // a stalled core ignores commands but still acks them
  assign exec = wr_fire && (aw_addr_r == OFF_CMD) && w_strb_r[0] && !sleep_r;

  assign rf_rd_addr = exec ? instr.file_reg_addr : faddr_r;

  rsse_alu u_alu
  (
    .op          (instr.op),
    .operand_f   (rf_rd_data),
    .working_reg (wreg_r),
    .literal     (instr.literal),
    .carry_in    (status_r[ST_C]),
    .res         (alu)
  );

  rsse_regfile #(.DEPTH(NREGS)) u_rf
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rd_addr (rf_rd_addr),
    .rd_data (rf_rd_data),
    .wr_en   (rf_wr_en),
    .wr_addr (rf_wr_addr),
    .wr_data (rf_wr_data)
  );

  // bus channel next state
  always_comb
  begin
    aw_have_nxt = aw_have_r;
    aw_addr_nxt = aw_addr_r;
    w_have_nxt  = w_have_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    // complete the write once both halves sit in the latches
    if (wr_fire)
    begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
    // reads answer one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFF_WREG:   rdata_nxt = {24'h000000, wreg_r};
        OFF_STATUS: rdata_nxt = {24'h000000, status_r};
        OFF_FADDR:  rdata_nxt = {25'h0000000, faddr_r};
        OFF_FDATA:  rdata_nxt = {24'h000000, rf_rd_data};
        OFF_CORE:   rdata_nxt = {8'h00, 1'b0, presc_r, wdt_r, 7'h00, sleep_r};
        default:    rdata_nxt = 32'h00000000;
      endcase
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
  end

  // core next state: execute, direct pokes, watchdog, wake
  always_comb
  begin
    wreg_nxt   = wreg_r;
    status_nxt = status_r;
    faddr_nxt  = faddr_r;
    sleep_nxt  = sleep_r;
    rf_wr_en   = 1'b0;
    rf_wr_addr = faddr_r;
    rf_wr_data = w_data_r[DATA_W-1:0];
    // watchdog runs off the prescaler while awake
    presc_nxt  = sleep_r ? presc_r : PRESC_W'(presc_r + 1'b1);
    wdt_nxt    = (!sleep_r && presc_r == '1) ? WDT_W'(wdt_r + 1'b1) : wdt_r;
    if (sleep_r && wake)
    begin
      sleep_nxt = 1'b0;                            // wake-up source restarts the core
    end
    if (exec)
    begin
      case (instr.op)
        OP_RLC, OP_RRC:
        begin
          status_nxt[ST_C] = alu.carry_flag;
          if (instr.dest_select)
          begin
            rf_wr_en   = 1'b1;
            rf_wr_addr = instr.file_reg_addr;
            rf_wr_data = alu.value;
          end
          else
          begin
            wreg_nxt = alu.value;
          end
        end
        OP_SUB:
        begin
          wreg_nxt          = alu.value;
          status_nxt[ST_C]  = alu.carry_flag;
          status_nxt[ST_DC] = alu.digit_carry_flag;
          status_nxt[ST_Z]  = alu.zero_flag;
        end
        OP_SLP:
        begin
          wdt_nxt           = '0;
          presc_nxt         = '0;
          status_nxt[ST_PD] = 1'b0;
          status_nxt[ST_TO] = 1'b1;
          sleep_nxt         = 1'b1;
        end
        default:
        begin
          sleep_nxt = sleep_r;
        end
      endcase
    end
    else if (wr_fire)
    begin
      case (aw_addr_r)
        OFF_WREG:   wreg_nxt   = wreg_mg[DATA_W-1:0];
        OFF_STATUS: status_nxt = status_mg[7:0];
        OFF_FADDR:  faddr_nxt  = faddr_mg[ADDR_W-1:0];
        OFF_FDATA:  rf_wr_en   = w_strb_r[0];
        default:    faddr_nxt  = faddr_r;
      endcase
    end
  end

  // register all state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_have_r  <= 1'b0;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= RESP_OKAY;
      wreg_r    <= '0;
      status_r  <= STATUS_RST;
      faddr_r   <= '0;
      wdt_r     <= '0;
      presc_r   <= '0;
      sleep_r   <= 1'b0;
    end
    else
    begin
      aw_have_r <= aw_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_have_r  <= w_have_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      wreg_r    <= wreg_nxt;
      status_r  <= status_nxt;
      faddr_r   <= faddr_nxt;
      wdt_r     <= wdt_nxt;
      presc_r   <= presc_nxt;
      sleep_r   <= sleep_nxt;
    end
  end
endmodule
`default_nettype wire

// [sim/rsse_core_asserts.sv]
// concurrent checks on the executor's bus, sleep and oscillator pins
`timescale 1ns/1ps
`default_nettype none
module rsse_core_asserts
  import rsse_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        wake,
  input wire logic        osc_run,
  input wire logic        sleeping
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0]  wa_r, wa_nxt, ra_r, ra_nxt;  // last taken addresses
  logic [31:0] wd_r, wd_nxt;                // last taken write word
  logic        ws_r, ws_nxt;                // low lane strobe of it
  logic        slp_r, stw_r, stw_nxt;       // status written since sleep
  logic        is_slp;                      // last write was a sleep command
  // capture per handshake; a status write spoils the sleep status check
  always_comb
  begin
    wa_nxt  = wa_r;
    wd_nxt  = wd_r;
    ws_nxt  = ws_r;
    ra_nxt  = ra_r;
    stw_nxt = stw_r;
    if (s_axi_awvalid && s_axi_awready) wa_nxt = s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_nxt = s_axi_wdata;
    if (s_axi_wvalid && s_axi_wready) ws_nxt = s_axi_wstrb[0];
    if (s_axi_arvalid && s_axi_arready) ra_nxt = s_axi_araddr;
    if (sleeping && !slp_r) stw_nxt = 1'b0;
    if (s_axi_bvalid && wa_r == OFF_STATUS) stw_nxt = 1'b1;
    if (!aresetn) stw_nxt = 1'b1;
  end
  // plain registers only
  always_ff @(posedge aclk)
  begin
    wa_r  <= wa_nxt;
    wd_r  <= wd_nxt;
    ws_r  <= ws_nxt;
    ra_r  <= ra_nxt;
    stw_r <= stw_nxt;
    slp_r <= sleeping;
  end
  assign is_slp = (wa_r == OFF_CMD) && ws_r && (wd_r[1:0] == 2'h3);
  chk_osc_sleep_pair: assert property (osc_run == !sleeping)
    else $error("oscillator enable disagrees with sleep state");
  chk_sleep_entry: assert property ($rose(s_axi_bvalid) && is_slp |-> sleeping)
    else $error("sleep command did not enter sleep");
  chk_wake_exit: assert property (sleeping && wake |=> !sleeping)
    else $error("wake did not end sleep");
  chk_wd_held_zero: assert property ($rose(s_axi_rvalid) && ra_r == OFF_CORE && $past(sleeping)
    |-> s_axi_rdata[22:8] == 15'h0000)
    else $error("watchdog not cleared while asleep");
  chk_status_sleep: assert property ($rose(s_axi_rvalid) && ra_r == OFF_STATUS && $past(sleeping)
    && !stw_r |-> s_axi_rdata[4:3] == 2'b10)
    else $error("timeout or powerdown wrong after sleep");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid)
    else $error("read response late");
  chk_unmapped_read: assert property ($rose(s_axi_rvalid) && ra_r > OFF_CORE
    |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  cov_sleep: cover property ($rose(sleeping));
  cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cov_sub: cover property ($rose(s_axi_bvalid) && wa_r == OFF_CMD && wd_r[1:0] == 2'h2);
endmodule
bind rsse_core rsse_core_asserts u_rsse_core_asserts (.*);
`default_nettype wire

// [sim/test_rsse_core.sv]
// self-checking bench for the executor over its register bus
`timescale 1ns/1ps
`default_nettype none
module test_rsse_core;
  import rsse_pkg::*;
  logic        aclk, aresetn, wake, osc_run, sleeping;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          n_mismatch, n_compared;
  rsse_core u_rsse_core (.*);
  // free running 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic give_verdict();
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp_data(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t data %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t resp %b expected %b", $time, g, e);
    end
  endtask
  // bus write; readiness sampled mid-cycle, acted on at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    int         n;
    logic       ah, wh, bh;
    logic [1:0] r;
    n = 0;
    bh = 1'b0;
    r = 2'bxx;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!bh && n < 64)
    begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      n++;
    end
    cmp_resp(bh ? r : 2'bxx, er);
  endtask
  // bus read, masked compare of the returned word
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff,
                     input logic [1:0] er = RESP_OKAY);
    int          n;
    logic        ah, rh;
    logic [31:0] d;
    logic [1:0]  r;
    n = 0;
    rh = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!rh && n < 64)
    begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
      n++;
    end
    cmp_resp(rh ? r : 2'bxx, er);
    cmp_data(d & m, e);
  endtask
  // issue one instruction through the command word
  task automatic exec(input rsse_op_e op, input logic d, input logic [6:0] f, input logic [7:0] k);
    wr(OFF_CMD, {8'h00, k, 1'b0, f, 5'h00, d, op});
  endtask
  task automatic fset(input logic [6:0] f, input logic [7:0] v);
    wr(OFF_FADDR, {25'h0, f});
    wr(OFF_FDATA, {24'h0, v});
  endtask
  task automatic fchk(input logic [6:0] f, input logic [7:0] v);
    wr(OFF_FADDR, {25'h0, f});
    chk(OFF_FDATA, {24'h0, v});
  endtask
  // watchdog: whole sequence needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    logic [7:0] sw [5];
    logic [7:0] sk [5];
    logic [7:0] ex;
    sw = '{8'h05, 8'h06, 8'h0f, 8'h21, 8'h00};
    sk = '{8'h05, 8'h05, 8'h10, 8'h13, 8'hff};
    {aresetn, wake, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;  // always ready: answers taken at once
    s_axi_rready = 1'b1;
    n_mismatch = 0;
    n_compared = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    chk(OFF_STATUS, 32'h18);
    chk(OFF_WREG, 32'h0);
    chk(OFF_CORE, 32'h0, 32'h1);
    chk(8'h40, 32'h0, 32'hffffffff, RESP_SLVERR);
    wr(8'h40, 32'h1, RESP_SLVERR);
    // rotates: only carry moves, other flags held high to see them kept
    fset(7'h05, 8'he6);
    wr(OFF_STATUS, 32'h1e);
    exec(OP_RLC, 1'b0, 7'h05, 8'h00);
    chk(OFF_WREG, 32'hcc);
    chk(OFF_STATUS, 32'h1f);
    fchk(7'h05, 8'he6);
    fset(7'h7f, 8'h01);
    exec(OP_RRC, 1'b1, 7'h7f, 8'h00);
    fchk(7'h7f, 8'h80);
    chk(OFF_WREG, 32'hcc);
    exec(OP_RRC, 1'b1, 7'h7f, 8'h00);
    fchk(7'h7f, 8'hc0);
    chk(OFF_STATUS, 32'h1e);
    exec(OP_RLC, 1'b1, 7'h7f, 8'h00);
    fchk(7'h7f, 8'h80);
    chk(OFF_STATUS, 32'h1f);
    exec(OP_RRC, 1'b0, 7'h7f, 8'h00);
    chk(OFF_WREG, 32'hc0);
    fchk(7'h7f, 8'h80);
    // subtract from literal across borrow and nibble-borrow corners
    for (int i = 0; i < 5; i++)
    begin
      wr(OFF_STATUS, 32'h18);
      wr(OFF_WREG, {24'h0, sw[i]});
      exec(OP_SUB, 1'b0, 7'h00, sk[i]);
      ex = sk[i] - sw[i];
      chk(OFF_WREG, {24'h0, ex});
      chk(OFF_STATUS, {29'h3, ex == 8'h00, sw[i][3:0] <= sk[i][3:0], sw[i] <= sk[i]});
    end
    // a command without its low byte lane is acknowledged but not run
    s_axi_wstrb <= 4'he;
    exec(OP_SUB, 1'b0, 7'h00, 8'hff);
    s_axi_wstrb <= 4'hf;
    chk(OFF_WREG, 32'hff);
    chk(OFF_STATUS, 32'h1b);
    // sleep keeps low flags, stops the watchdog and further commands
    wr(OFF_STATUS, 32'h0f);
    exec(OP_SLP, 1'b0, 7'h00, 8'h00);
    cmp_data({30'h0, osc_run, sleeping}, 32'h1);
    chk(OFF_STATUS, 32'h17);
    repeat (300) @(posedge aclk);
    chk(OFF_CORE, 32'h1, 32'h7fffff);
    exec(OP_RRC, 1'b0, 7'h7f, 8'h00);
    chk(OFF_WREG, 32'hff);
    wake <= 1'b1;
    @(posedge aclk);
    wake <= 1'b0;
    @(negedge aclk);
    cmp_data({30'h0, osc_run, sleeping}, 32'h2);
    @(posedge aclk);
    give_verdict();
  end
endmodule
`default_nettype wire
